// [hw/sac_pkg.sv]
// sac_pkg: constants, encodings and types shared by the converter control block.
// assumes a single 10 MHz system clock and an active-low asynchronous reset.
package sac_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int SYS_CLK_MHZ = 10;
  localparam int TRACK_TIME_NS = 1500;
  localparam int TRACK_CYC = (TRACK_TIME_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int SAR_DIV = 4;
  localparam logic [4:0] TRACK_LAST = 5'(TRACK_CYC - 1);
  localparam logic [1:0] DIV_LAST = 2'(SAR_DIV - 1);
  // ----------------------------------------------------------------
  // result layout
  // ----------------------------------------------------------------
  localparam int RES_W = 12;
  localparam logic [3:0] MSB_IDX = 4'hb;
  localparam logic [3:0] LSB_IDX_12 = 4'h0;
  localparam logic [3:0] LSB_IDX_10 = 4'h2;
  localparam logic [11:0] RESULT_RESET = 12'h000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  // ----------------------------------------------------------------
  // multiplexer, amplifier and reference
  // ----------------------------------------------------------------
  localparam logic [3:0] CHAN_TEMP = 4'h8;
  localparam logic [3:0] PAIR_CFG_RESET = 4'h0;
  localparam logic [2:0] GAIN_X1 = 3'h0;
  localparam logic [2:0] GAIN_X2 = 3'h1;
  localparam logic [2:0] GAIN_X4 = 3'h2;
  localparam logic [2:0] GAIN_X8 = 3'h3;
  localparam logic [2:0] GAIN_X16 = 3'h4;
  localparam logic [2:0] GAIN_X0P5 = 3'h6;
  localparam logic REF_EXT_PIN = 1'b0;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SAC_START_SOFT,
    SAC_START_TMR2,
    SAC_START_TMR3,
    SAC_START_EXT
  } sac_start_t;
  typedef enum logic [1:0] {
    SAC_IDLE,
    SAC_TRACK,
    SAC_CONVERT,
    SAC_FINISH
  } sac_seq_state_t;
endpackage

// [hw/sac_conv_if.sv]
// sac_conv_if: start/done handshake and result word between control and sequencer.
// assumes both ends run on the system clock.
`timescale 1ns/100ps
interface sac_conv_if;
  logic start;
  logic abort;
  logic mode12;
  logic busy;
  logic done;
  logic [11:0] result;
  modport ctl (output start, output abort, output mode12, input busy, input done, input result);
  modport seq (input start, input abort, input mode12, output busy, output done, output result);
endinterface

// [hw/sac_trig.sv]
// sac_trig: synchronises the pin and timer start sources and picks the selected one.
// assumes timer and external starts are asynchronous levels; soft start is a clk pulse.
`timescale 1ns/100ps
module sac_trig
  import sac_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic [1:0] start_mode_in,
  input wire logic soft_start_in,
  input wire logic tmr2_ovf_in,
  input wire logic tmr3_ovf_in,
  input wire logic ext_start_in,
  output logic trig_out
);
  // ----------------------------------------------------------------
  // synchronisers and edge detect
  // ----------------------------------------------------------------
  logic [2:0] s1_q, s2_q, s3_q;
  logic [2:0] s1_d, rise;
  logic trig_d, trig_q;
  always_comb begin
    s1_d = {ext_start_in, tmr3_ovf_in, tmr2_ovf_in};
    rise = s2_q & ~s3_q;
    unique case (sac_start_t'(start_mode_in))
      SAC_START_SOFT: trig_d = soft_start_in;
      SAC_START_TMR2: trig_d = rise[0];
      SAC_START_TMR3: trig_d = rise[1];
      SAC_START_EXT: trig_d = rise[2];
    endcase
  end
  // s1_q feeds only s2_q
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
      s3_q <= 3'h0;
      trig_q <= 1'b0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      trig_q <= trig_d;
    end
  end
  assign trig_out = trig_q;
endmodule

// [hw/sac_sar_seq.sv]
// sac_sar_seq: track phase then one bit per divider tick of successive approximation.
// assumes the analog comparator output is asynchronous and settles within one tick.
`timescale 1ns/100ps
module sac_sar_seq
  import sac_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  sac_conv_if.seq cv,
  input wire logic cmp_in,
  output logic [11:0] trial_code_out,
  output logic track_out
);
  sac_seq_state_t state_q, state_d;
  logic [4:0] cnt_q, cnt_d;
  logic [1:0] div_q, div_d;
  logic [3:0] bit_q, bit_d;
  logic [11:0] code_q, code_d;
  logic cmp1_q, cmp2_q;
  logic last_bit;
  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    div_d = div_q;
    bit_d = bit_q;
    code_d = code_q;
    last_bit = (bit_q == (cv.mode12 ? LSB_IDX_12 : LSB_IDX_10));
    unique case (state_q)
      SAC_IDLE: begin
        if (cv.start) begin
          state_d = SAC_TRACK;
          cnt_d = 5'h00;
          code_d = RESULT_RESET;
        end
      end
      SAC_TRACK: begin
        cnt_d = cnt_q + 5'h01;
        if (cnt_q == TRACK_LAST) begin
          state_d = SAC_CONVERT;
          bit_d = MSB_IDX;
          div_d = 2'h0;
          code_d[MSB_IDX] = 1'b1;
        end
      end
      SAC_CONVERT: begin
        div_d = div_q + 2'h1;
        if (div_q == DIV_LAST) begin
          // comparator low means the trial overshot the input
          if (!cmp2_q) begin
            code_d[bit_q] = 1'b0;
          end
          if (last_bit) begin
            state_d = SAC_FINISH;
          end else begin
            bit_d = bit_q - 4'h1;
            code_d[bit_q - 4'h1] = 1'b1;
          end
        end
      end
      SAC_FINISH: state_d = SAC_IDLE;
    endcase
    if (cv.abort) begin
      state_d = SAC_IDLE;
    end
  end
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q <= SAC_IDLE;
      cnt_q <= 5'h00;
      div_q <= 2'h0;
      bit_q <= MSB_IDX;
      code_q <= RESULT_RESET;
      cmp1_q <= 1'b0;
      cmp2_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      div_q <= div_d;
      bit_q <= bit_d;
      code_q <= code_d;
      cmp1_q <= cmp_in;
      cmp2_q <= cmp1_q;
    end
  end
  assign cv.busy = (state_q != SAC_IDLE);
  assign cv.done = (state_q == SAC_FINISH);
  assign cv.result = cv.mode12 ? code_q : {2'h0, code_q[11:2]};
  assign trial_code_out = code_q;
  assign track_out = (state_q == SAC_TRACK);
endmodule

// [hw/sac_conv_ctrl.sv]
// sac_conv_ctrl: top of the converter control block; configuration, capture, window, flags.
// assumes control inputs come from processor registers on the system clock;
// timer, external start and comparator inputs arrive asynchronously.
`timescale 1ns/100ps
module sac_conv_ctrl
  import sac_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic conv_enable_in,
  input wire logic [1:0] start_mode_in,
  input wire logic soft_start_in,
  input wire logic tmr2_ovf_in,
  input wire logic tmr3_ovf_in,
  input wire logic ext_start_in,
  input wire logic res_12bit_in,
  input wire logic left_justify_in,
  input wire logic done_irq_en_in,
  input wire logic done_clear_in,
  input wire logic window_inside_in,
  input wire logic [11:0] window_lo_in,
  input wire logic [11:0] window_hi_in,
  input wire logic window_clear_in,
  input wire logic [3:0] channel_select_field_in,
  input wire logic [3:0] pair_config_in,
  input wire logic pair_config_wr_in,
  input wire logic [2:0] gain_select_field_in,
  input wire logic gain_wr_in,
  input wire logic ref_select_in,
  input wire logic cmp_in,
  output logic power_en_out,
  output logic track_out,
  output logic [11:0] trial_code_out,
  output logic busy_out,
  output logic done_flag_out,
  output logic done_irq_out,
  output logic window_irq_out,
  output logic [7:0] result_high_out,
  output logic [7:0] result_low_out,
  output logic [3:0] mux_pos_out,
  output logic [3:0] mux_neg_out,
  output logic mux_diff_out,
  output logic temp_sel_out,
  output logic [2:0] pga_gain_out,
  output logic ref_dac_sel_out
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // packs a right-aligned result into the 16-bit register pair
  function automatic logic [15:0] justify(input logic [11:0] r, input logic m12, input logic left);
    logic [15:0] w;
    w = {4'h0, r};
    if (left) begin
      w = m12 ? {r, 4'h0} : {r[9:0], 6'h00};
    end
    return w;
  endfunction
  // window compare on the right-aligned value
  function automatic logic in_window(input logic [11:0] r, input logic [11:0] lo, input logic [11:0] hi);
    return (r >= lo) && (r <= hi);
  endfunction
  // ----------------------------------------------------------------
  // sub-blocks
  // ----------------------------------------------------------------
  sac_conv_if cv ();
  logic trig;
  logic [11:0] trial_code;
  logic track;
  sac_trig u_trig (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .start_mode_in(start_mode_in),
    .soft_start_in(soft_start_in),
    .tmr2_ovf_in(tmr2_ovf_in),
    .tmr3_ovf_in(tmr3_ovf_in),
    .ext_start_in(ext_start_in),
    .trig_out(trig)
  );
  sac_sar_seq u_seq (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .cv(cv.seq),
    .cmp_in(cmp_in),
    .trial_code_out(trial_code),
    .track_out(track)
  );
  // ----------------------------------------------------------------
  // start path
  // ----------------------------------------------------------------
  logic power_q, power_d;
  logic mode12_q, mode12_d;
  always_comb begin
    power_d = conv_enable_in;
    mode12_d = mode12_q;
    // width is frozen while busy so a mid-conversion change cannot corrupt the word
    if (!cv.busy) begin
      mode12_d = res_12bit_in;
    end
  end
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      power_q <= 1'b0;
      mode12_q <= 1'b1;
    end else begin
      power_q <= power_d;
      mode12_q <= mode12_d;
    end
  end
  assign cv.mode12 = mode12_q;
  assign cv.start = trig && power_q && !cv.busy;
  assign cv.abort = !power_q;
  // ----------------------------------------------------------------
  // capture, flags and window
  // ----------------------------------------------------------------
  logic [7:0] res_hi_q, res_hi_d;
  logic [7:0] res_lo_q, res_lo_d;
  logic done_flag_q, done_flag_d;
  logic done_irq_q, done_irq_d;
  logic win_flag_q, win_flag_d;
  logic busy_q, busy_d;
  logic [15:0] packed_res;
  logic win_hit;
  always_comb begin
    packed_res = justify(cv.result, mode12_q, left_justify_in);
    win_hit = (in_window(cv.result, window_lo_in, window_hi_in) == window_inside_in);
    res_hi_d = res_hi_q;
    res_lo_d = res_lo_q;
    done_flag_d = done_flag_q;
    win_flag_d = win_flag_q;
    if (done_clear_in) begin
      done_flag_d = 1'b0;
    end
    if (window_clear_in) begin
      win_flag_d = 1'b0;
    end
    // a completion in the clear cycle still sets the flag
    if (cv.done) begin
      res_hi_d = packed_res[15:8];
      res_lo_d = packed_res[7:0];
      done_flag_d = 1'b1;
      if (win_hit) begin
        win_flag_d = 1'b1;
      end
    end
    done_irq_d = done_flag_d && done_irq_en_in;
    busy_d = cv.busy;
  end
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      res_hi_q <= BYTE_RESET;
      res_lo_q <= BYTE_RESET;
      done_flag_q <= 1'b0;
      done_irq_q <= 1'b0;
      win_flag_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      res_hi_q <= res_hi_d;
      res_lo_q <= res_lo_d;
      done_flag_q <= done_flag_d;
      done_irq_q <= done_irq_d;
      win_flag_q <= win_flag_d;
      busy_q <= busy_d;
    end
  end
  // ----------------------------------------------------------------
  // multiplexer, amplifier and reference
  // ----------------------------------------------------------------
  logic [3:0] pair_q, pair_d;
  logic [2:0] gain_q, gain_d;
  logic [3:0] pos_q, pos_d;
  logic [3:0] neg_q, neg_d;
  logic diff_q, diff_d;
  logic temp_q, temp_d;
  logic ref_q, ref_d;
  logic pair_diff;
  always_comb begin
    pair_d = pair_q;
    gain_d = gain_q;
    if (pair_config_wr_in) begin
      pair_d = pair_config_in;
    end
    // unused gain codes are refused so the amplifier never sees an undefined setting
    if (gain_wr_in) begin
      unique case (gain_select_field_in)
        GAIN_X1, GAIN_X2, GAIN_X4, GAIN_X8, GAIN_X16, GAIN_X0P5: gain_d = gain_select_field_in;
        default: gain_d = gain_q;
      endcase
    end
    pair_diff = pair_q[channel_select_field_in[2:1]];
    temp_d = (channel_select_field_in >= CHAN_TEMP);
    pos_d = channel_select_field_in;
    neg_d = channel_select_field_in;
    diff_d = 1'b0;
    if (temp_d) begin
      pos_d = CHAN_TEMP;
      neg_d = CHAN_TEMP;
    end else if (pair_diff) begin
      pos_d = {channel_select_field_in[3:1], 1'b0};
      neg_d = {channel_select_field_in[3:1], 1'b1};
      diff_d = 1'b1;
    end
    ref_d = ref_select_in;
  end
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pair_q <= PAIR_CFG_RESET;
      gain_q <= GAIN_X1;
      pos_q <= 4'h0;
      neg_q <= 4'h0;
      diff_q <= 1'b0;
      temp_q <= 1'b0;
      ref_q <= REF_EXT_PIN;
    end else begin
      pair_q <= pair_d;
      gain_q <= gain_d;
      pos_q <= pos_d;
      neg_q <= neg_d;
      diff_q <= diff_d;
      temp_q <= temp_d;
      ref_q <= ref_d;
    end
  end
  // ----------------------------------------------------------------
  // analog-side registers
  // ----------------------------------------------------------------
  logic track_q;
  logic [11:0] trial_q;
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      track_q <= 1'b0;
      trial_q <= RESULT_RESET;
    end else begin
      track_q <= track && power_q;
      trial_q <= trial_code;
    end
  end
  assign power_en_out = power_q;
  assign track_out = track_q;
  assign trial_code_out = trial_q;
  assign busy_out = busy_q;
  assign done_flag_out = done_flag_q;
  assign done_irq_out = done_irq_q;
  assign window_irq_out = win_flag_q;
  assign result_high_out = res_hi_q;
  assign result_low_out = res_lo_q;
  assign mux_pos_out = pos_q;
  assign mux_neg_out = neg_q;
  assign mux_diff_out = diff_q;
  assign temp_sel_out = temp_q;
  assign pga_gain_out = gain_q;
  assign ref_dac_sel_out = ref_q;
endmodule

// [verif/sac_conv_ctrl_asserts.sv]
// port checker for the converter control top.
// assumes it is bound to sac_conv_ctrl on the system clock.
`timescale 1ns/100ps
module sac_conv_ctrl_asserts
  import sac_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic conv_enable_in,
  input wire logic done_irq_en_in,
  input wire logic done_clear_in,
  input wire logic window_clear_in,
  input wire logic [3:0] channel_select_field_in,
  input wire logic [2:0] gain_select_field_in,
  input wire logic gain_wr_in,
  input wire logic ref_select_in,
  input wire logic power_en_out,
  input wire logic track_out,
  input wire logic busy_out,
  input wire logic done_flag_out,
  input wire logic done_irq_out,
  input wire logic window_irq_out,
  input wire logic [3:0] mux_pos_out,
  input wire logic [3:0] mux_neg_out,
  input wire logic temp_sel_out,
  input wire logic [2:0] pga_gain_out,
  input wire logic ref_dac_sel_out
);
  // ----
  // helpers
  // ----
  // counts the track phase so its length can be checked at its end
  logic [5:0] trk_q;
  logic [5:0] trk_d;
  always_comb begin
    trk_d = track_out ? trk_q + 6'h01 : 6'h00;
  end
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      trk_q <= 6'h00;
    end else begin
      trk_q <= trk_d;
    end
  end
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  // five cycles, since the abort may take three stages to reach busy
  sequence off_s;
    !conv_enable_in [*5];
  endsequence
  sequence gain_ok_s;
    gain_wr_in && gain_select_field_in != 3'h5 && gain_select_field_in != 3'h7;
  endsequence
  sequence gain_bad_s;
    gain_wr_in && (gain_select_field_in == 3'h5 || gain_select_field_in == 3'h7);
  endsequence
  // ----
  // properties
  // ----
  power_follow_a: assert property (power_en_out == $past(conv_enable_in))
    else $error("power enable lag wrong");
  irq_gate_a: assert property (done_irq_out == (done_flag_out && $past(done_irq_en_in)))
    else $error("done interrupt not gated by enable");
  done_sticky_a: assert property ($fell(done_flag_out) |-> $past(done_clear_in))
    else $error("done flag dropped without clear");
  win_sticky_a: assert property ($fell(window_irq_out) |-> $past(window_clear_in))
    else $error("window flag dropped without clear");
  temp_route_a: assert property (channel_select_field_in[3] |=> temp_sel_out && mux_pos_out == CHAN_TEMP
    && mux_neg_out == CHAN_TEMP)
    else $error("temperature channel not routed");
  gain_load_a: assert property (gain_ok_s |=> pga_gain_out == $past(gain_select_field_in))
    else $error("gain not loaded");
  gain_keep_a: assert property (gain_bad_s |=> $stable(pga_gain_out))
    else $error("invalid gain code taken");
  ref_follow_a: assert property (ref_dac_sel_out == $past(ref_select_in))
    else $error("reference select lag wrong");
  track_len_a: assert property ($fell(track_out) && conv_enable_in |-> trk_q == 6'(TRACK_CYC))
    else $error("track phase length wrong");
  done_after_busy_a: assert property ($fell(busy_out) && conv_enable_in |-> ##[0:2] done_flag_out)
    else $error("conversion ended without done flag");
  off_idle_a: assert property (off_s |-> !busy_out && !track_out)
    else $error("converter active while disabled");
endmodule

bind sac_conv_ctrl sac_conv_ctrl_asserts i_chk (.clk_sys_in, .nrst_in, .conv_enable_in, .done_irq_en_in,
  .done_clear_in, .window_clear_in, .channel_select_field_in, .gain_select_field_in, .gain_wr_in,
  .ref_select_in, .power_en_out, .track_out, .busy_out, .done_flag_out, .done_irq_out, .window_irq_out,
  .mux_pos_out, .mux_neg_out, .temp_sel_out, .pga_gain_out, .ref_dac_sel_out);

// [verif/testbench.sv]
// self-checking bench for sac_conv_ctrl through its plain ports.
// assumes the analog input is a fixed level compared with the trial code.
`timescale 1ns/100ps
module testbench;
  import sac_pkg::*;
  logic clk_sys_in = 1'b0;
  logic nrst_in = 1'b0;
  logic conv_enable_in = 1'b0;
  logic [1:0] start_mode_in = 2'h0;
  logic soft_start_in = 1'b0, tmr2_ovf_in = 1'b0, tmr3_ovf_in = 1'b0, ext_start_in = 1'b0;
  logic res_12bit_in = 1'b1, left_justify_in = 1'b0, done_irq_en_in = 1'b0, done_clear_in = 1'b0;
  logic window_inside_in = 1'b0, window_clear_in = 1'b0;
  logic [11:0] window_lo_in = 12'h100, window_hi_in = 12'h300, ain = 12'h000;
  logic [3:0] channel_select_field_in = 4'h0, pair_config_in = 4'h0;
  logic pair_config_wr_in = 1'b0, gain_wr_in = 1'b0, ref_select_in = 1'b0, cmp_in;
  logic [2:0] gain_select_field_in = 3'h0, pga_gain_out;
  logic power_en_out, track_out, busy_out, done_flag_out, done_irq_out, window_irq_out;
  logic mux_diff_out, temp_sel_out, ref_dac_sel_out;
  logic [11:0] trial_code_out;
  logic [7:0] result_high_out, result_low_out;
  logic [3:0] mux_pos_out, mux_neg_out;
  int errors = 0;
  int n_tests = 0;
  // analog comparator stand-in, continuous like the real one
  assign cmp_in = ain >= trial_code_out;
  always #50 clk_sys_in = ~clk_sys_in;
  sac_conv_ctrl i_dut (.clk_sys_in, .nrst_in, .conv_enable_in, .start_mode_in, .soft_start_in,
    .tmr2_ovf_in, .tmr3_ovf_in, .ext_start_in, .res_12bit_in, .left_justify_in, .done_irq_en_in,
    .done_clear_in, .window_inside_in, .window_lo_in, .window_hi_in, .window_clear_in,
    .channel_select_field_in, .pair_config_in, .pair_config_wr_in, .gain_select_field_in, .gain_wr_in,
    .ref_select_in, .cmp_in, .power_en_out, .track_out, .trial_code_out, .busy_out, .done_flag_out,
    .done_irq_out, .window_irq_out, .result_high_out, .result_low_out, .mux_pos_out, .mux_neg_out,
    .mux_diff_out, .temp_sel_out, .pga_gain_out, .ref_dac_sel_out);
  // ----
  // tasks
  // ----
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask
  // pins are held four cycles so the synchroniser sees one clean edge
  task automatic fire(input logic [1:0] m);
    @(posedge clk_sys_in);
    case (m)
      2'h0: soft_start_in <= 1'b1;
      2'h1: tmr2_ovf_in <= 1'b1;
      2'h2: tmr3_ovf_in <= 1'b1;
      default: ext_start_in <= 1'b1;
    endcase
    @(posedge clk_sys_in);
    soft_start_in <= 1'b0;
    tick(3);
    {tmr2_ovf_in, tmr3_ovf_in, ext_start_in} <= 3'h0;
  endtask
  task automatic wait_done;
    int k;
    k = 0;
    while (done_flag_out !== 1'b1) begin
      @(negedge clk_sys_in);
      k++;
      if (k > 150) begin
        errors++;
        $display("[ERR] %0t no completion", $time);
        print_verdict();
      end
    end
  endtask
  task automatic clr;
    @(posedge clk_sys_in);
    {done_clear_in, window_clear_in} <= 2'h3;
    @(posedge clk_sys_in);
    {done_clear_in, window_clear_in} <= 2'h0;
    @(negedge clk_sys_in);
    chk(done_flag_out, 1'b0);
  endtask
  task automatic conv(input logic [1:0] m, input logic r12, input logic lj, input logic [11:0] a);
    logic [11:0] r;
    logic [15:0] w;
    @(posedge clk_sys_in);
    start_mode_in <= m;
    res_12bit_in <= r12;
    left_justify_in <= lj;
    done_irq_en_in <= lj;
    ain <= a;
    fire(m);
    wait_done();
    r = r12 ? a : {2'h0, a[11:2]};
    w = lj ? (r12 ? {r, 4'h0} : {r[9:0], 6'h0}) : {4'h0, r};
    @(negedge clk_sys_in);
    chk(result_high_out, w[15:8]);
    chk(result_low_out, w[7:0]);
    chk(done_irq_out, lj);
    chk(window_irq_out, (r >= window_lo_in && r <= window_hi_in) == window_inside_in);
    // the last trial code left on the converter dac is the converted word, low bits unused in 10-bit
    chk(trial_code_out, r12 ? a : {a[11:2], 2'h0});
    clr();
  endtask
  task automatic setmux(input logic [3:0] p, input logic [3:0] c);
    @(posedge clk_sys_in);
    pair_config_in <= p;
    pair_config_wr_in <= 1'b1;
    channel_select_field_in <= c;
    ref_select_in <= p[1];
    @(posedge clk_sys_in);
    pair_config_wr_in <= 1'b0;
    tick(2);
    @(negedge clk_sys_in);
  endtask
  // ----
  // sequence
  // ----
  initial begin
    logic [11:0] tab [4];
    logic [2:0] g;
    tab = '{12'h100, 12'hc3f, 12'h300, 12'hffc};
    g = GAIN_X1;
    tick(10);
    nrst_in <= 1'b1;
    @(negedge clk_sys_in);
    chk(pga_gain_out, GAIN_X1);
    chk(mux_diff_out, 1'b0);
    fire(2'h0);
    tick(90);
    @(negedge clk_sys_in);
    chk(done_flag_out, 1'b0);
    chk(power_en_out, 1'b0);
    @(posedge clk_sys_in);
    conv_enable_in <= 1'b1;
    for (int j = 0; j < 2; j++) begin
      @(posedge clk_sys_in);
      window_inside_in <= j[0];
      for (int i = 0; i < 4; i++) conv(2'(i), ~i[0], i[1], tab[i]);
    end
    @(posedge clk_sys_in);
    start_mode_in <= 2'h0;
    fire(2'h0);
    tick(8);
    @(negedge clk_sys_in);
    chk(busy_out, 1'b1);
    fire(2'h0);
    wait_done();
    clr();
    // unselected sources must not start anything
    fire(2'h1);
    fire(2'h3);
    tick(90);
    @(negedge clk_sys_in);
    chk(done_flag_out, 1'b0);
    fire(2'h0);
    tick(20);
    conv_enable_in <= 1'b0;
    tick(6);
    conv_enable_in <= 1'b1;
    tick(90);
    @(negedge clk_sys_in);
    chk(done_flag_out, 1'b0);
    conv(2'h0, 1'b1, 1'b0, 12'h5a5);
    setmux(4'h2, 4'h3);
    chk({mux_diff_out, mux_pos_out, mux_neg_out}, 9'h123);
    chk(ref_dac_sel_out, 1'b1);
    setmux(4'h0, 4'h3);
    chk({mux_diff_out, mux_pos_out}, 5'h03);
    chk(ref_dac_sel_out, 1'b0);
    for (int k = 0; k < 8; k++) begin
      @(posedge clk_sys_in);
      gain_select_field_in <= 3'(k);
      gain_wr_in <= 1'b1;
      @(posedge clk_sys_in);
      gain_wr_in <= 1'b0;
      tick(2);
      @(negedge clk_sys_in);
      if (k != 5 && k != 7) g = 3'(k);
      chk(pga_gain_out, g);
    end
    setmux(4'h0, CHAN_TEMP);
    chk({temp_sel_out, mux_pos_out}, 5'h18);
    chk(pga_gain_out, GAIN_X0P5);
    print_verdict();
  end
endmodule
